// [sct_pkg.sv]
// Constants and types of the serial calendar timekeeper
// Function
// - All time values held as BCD digits
// - Eight byte registers with calendar ranges
// - Single-byte and burst transfer formats
// - Command byte opens every transfer
// - Command bit 0: 0 write, 1 read
// - Command bits 3..1 select the register
// - Single command is 1000, select, direction
// - Seconds bit 7 halts the oscillator
// - Lock bit 7 refuses writes, transfer_enable_line zero
// - Hours bit 7 picks 12 or 24 hour
// - Burst reads move all eight registers, burst writes only the first seven
// - Hours bit 5 is PM or tens
// - Sample on rising, drive after falling, LSB first
// - Enable low aborts, data line released
package sct_pkg;
	// Clock and one-second period
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned SECOND_NS     = 1000000000;
	localparam int unsigned TICK_CYCLES   = SECOND_NS / CLK_PERIOD_NS;
	localparam int unsigned TICK_W        = 24;
	// Register indices
	localparam logic [2:0] IDX_SEC  = 3'h0;
	localparam logic [2:0] IDX_MIN  = 3'h1;
	localparam logic [2:0] IDX_HOUR = 3'h2;
	localparam logic [2:0] IDX_DATE = 3'h3;
	localparam logic [2:0] IDX_MON  = 3'h4;
	localparam logic [2:0] IDX_WDAY = 3'h5;
	localparam logic [2:0] IDX_YEAR = 3'h6;
	localparam logic [2:0] IDX_LOCK = 3'h7;
	// Field positions
	localparam int unsigned HALT_BIT   = 7;
	localparam int unsigned LOCK_BIT   = 7;
	localparam int unsigned HOUR12_BIT = 7;
	localparam int unsigned PM_BIT     = 5;
	localparam int unsigned CMD_DIR    = 0;
	// Command prefixes
	localparam logic [3:0] CMD_SINGLE = 4'h8;
	localparam logic [6:0] CMD_BURST  = 7'h5F;
	// Writable bits per register, lock first
	localparam logic [7:0][7:0] REG_MASK =
		{8'h80, 8'hFF, 8'h07, 8'h1F, 8'h3F, 8'hBF, 8'h7F, 8'hFF};
	// Reset contents: halted, locked, first of January
	localparam logic [7:0][7:0] REG_RESET =
		{8'h80, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h80};
	// BCD limits
	localparam logic [7:0] BCD_59 = 8'h59;
	localparam logic [7:0] BCD_23 = 8'h23;
	localparam logic [7:0] BCD_12 = 8'h12;
	localparam logic [7:0] BCD_11 = 8'h11;
	localparam logic [7:0] BCD_99 = 8'h99;
	localparam logic [7:0] BCD_07 = 8'h07;
	localparam logic [7:0] BCD_01 = 8'h01;
	// Write word: burst flag, index, data
	localparam int unsigned WORD_W     = 12;
	localparam int unsigned FIFO_DEPTH = 4;
endpackage

// [sct_stream_if.sv]
// Valid/ready word stream between timekeeper modules
`timescale 1ns/100ps
interface sct_stream_if #(parameter int unsigned WIDTH = 8);
	logic             valid; // Word offered
	logic             ready; // Word taken
	logic [WIDTH-1:0] data;  // Word
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// [sct_fifo.sv]
// Small flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sct_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic   clock_i,
	input  wire logic   rst_i,
	sct_stream_if.snk   push,
	sct_stream_if.src   pop
);
	localparam int unsigned AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage
		logic [AW:0]                 wp;  // Write pointer, wrap bit on top
		logic [AW:0]                 rp;  // Read pointer
	} sct_fifo_s;
	sct_fifo_s f_r, f_nxt;
	logic full, empty;
	// Full when indices match and wrap bits differ
	assign empty = (f_r.wp == f_r.rp);
	assign full  = (f_r.wp[AW-1:0] == f_r.rp[AW-1:0]) && (f_r.wp[AW] != f_r.rp[AW]);
	assign push.ready = !full;
	assign pop.valid  = !empty;
	assign pop.data   = f_r.mem[f_r.rp[AW-1:0]];
	// Pointer and storage update
	always_comb begin
		f_nxt = f_r;
		if (push.valid && !full) begin
			f_nxt.mem[f_r.wp[AW-1:0]] = push.data;
			f_nxt.wp = f_r.wp + 1'b1;
		end
		if (pop.ready && !empty) begin
			f_nxt.rp = f_r.rp + 1'b1;
		end
	end
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			f_r <= '0;
		end else begin
			f_r <= f_nxt;
		end
	end
	// Occupancy never passes the depth
	AST_FIFO_BOUND: assert property (@(posedge clock_i) disable iff (rst_i)
		(f_r.wp - f_r.rp) <= (AW+1)'(DEPTH)) else $error("fifo overfilled");
	COV_FIFO_FULL: cover property (@(posedge clock_i) disable iff (rst_i) full);
endmodule

// [sct_timekeeper.sv]
// Serial calendar timekeeper: three-wire link and BCD calendar
`timescale 1ns/100ps
module sct_timekeeper #(
	parameter int unsigned TICK_CYCLES = sct_pkg::TICK_CYCLES
) (
	input  wire logic clock_i,              // System clock
	input  wire logic rst_i,                // Asynchronous reset
	input  wire logic shift_clock_i,        // Host shift clock
	input  wire logic transfer_enable_line_i, // High during a frame
	input  wire logic data_line_i,          // Data pin input
	output logic      data_line_o,          // Data pin output
	output logic      data_line_oe_n_o      // Low while driving
);
	// Next BCD value, units 9 rolls into tens
	function automatic logic [7:0] sct_bcd_inc(input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (v[3:0] >= 4'h9) begin
			r[3:0] = 4'h0;
			r[7:4] = v[7:4] + 4'h1;
		end else begin
			r[3:0] = v[3:0] + 4'h1;
		end
		return r;
	endfunction

	// Last day of a month, leap years by BCD year
	function automatic logic [7:0] sct_month_end(input logic [7:0] mon,
		input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
		             : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon[4:0])
			5'h02: begin
				sct_month_end = leap ? 8'h29 : 8'h28;
			end
			5'h04, 5'h06, 5'h09, 5'h11: begin
				sct_month_end = 8'h30;
			end
			default: begin
				sct_month_end = 8'h31;
			end
		endcase
	endfunction

	// Lowest set bit of a slot mask, 0 when none is set
	function automatic logic [2:0] sct_first(input logic [7:0] p);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (p[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	// Link side, reset by the enable pin so any frame can be aborted
	typedef struct packed {
		logic [7:0] cmd;      // Command shifted in
		logic       cmd_done; // Command complete
		logic [2:0] bit_cnt;  // Bit within byte
		logic [7:0] shift;    // Write data shifted in
		logic [2:0] idx;      // Register in use
		logic       finished; // Rest of frame ignored until enable drops
	} sct_link_s;
	// Write mailbox, one slot per register: a burst byte every eight shift
	// clocks outruns the system clock, so one shared word would be overwritten
	// before the system side could take it; survives frame end
	typedef struct packed {
		logic [7:0][7:0] data;  // Last byte written per register
		logic [7:0]      burst; // Byte came from a burst
		logic [7:0]      tog;   // Flips per new byte
	} sct_mbox_s;
	// Clock domain state
	typedef struct packed {
		logic [7:0][7:0]               regs;    // Live registers
		logic [7:0][7:0]               shadow;  // Frozen copy for the link
		logic [sct_pkg::TICK_W-1:0]    prescale; // One-second divider
		logic                          en_s1;   // Enable sync stage 1
		logic                          en_s2;   // Enable sync stage 2
		logic [7:0]                    tog_s1;  // Mailbox sync stage 1, per slot
		logic [7:0]                    tog_s2;  // Mailbox sync stage 2, per slot
		logic [7:0]                    tog_s3;  // Edge reference, per slot
		logic [7:0]                    pending; // Slots waiting for FIFO
	} sct_sys_s;

	sct_link_s l_r, l_nxt;
	sct_mbox_s m_r, m_nxt;
	sct_sys_s  s_r, s_nxt;
	logic      link_rst;   // Link reset: chip reset or enable low
	logic      is_single;  // Current command is single byte
	logic      is_burst;   // Current command is burst
	logic      drive_nxt;  // Data line to be driven
	logic      tick;       // One second elapsed, oscillator running
	logic [sct_pkg::TICK_W-1:0] tick_last;
	logic [2:0] pick;       // Mailbox slot offered to the FIFO

	sct_stream_if #(.WIDTH(sct_pkg::WORD_W)) wr_in ();
	sct_stream_if #(.WIDTH(sct_pkg::WORD_W)) wr_out ();

	assign link_rst = rst_i | !transfer_enable_line_i;
	assign tick_last = sct_pkg::TICK_W'(TICK_CYCLES - 1);

	// Command decode: test and unknown codes are not served
	assign is_single = (l_r.cmd[7:4] == sct_pkg::CMD_SINGLE);
	assign is_burst  = (l_r.cmd[7:1] == sct_pkg::CMD_BURST);

	// Rising edge: sample command then data, LSB first
	always_comb begin
		logic [7:0] c;
		logic [7:0] d;
		c = {data_line_i, l_r.cmd[7:1]};
		d = {data_line_i, l_r.shift[7:1]};
		l_nxt = l_r;
		m_nxt = m_r;
		if (!l_r.finished) begin
			l_nxt.bit_cnt = l_r.bit_cnt + 3'h1;
			if (!l_r.cmd_done) begin
				l_nxt.cmd = c;
				if (l_r.bit_cnt == 3'h7) begin
					l_nxt.cmd_done = 1'b1;
					if (c[7:1] == sct_pkg::CMD_BURST) begin
						l_nxt.idx = sct_pkg::IDX_SEC;
					end else if (c[7:4] == sct_pkg::CMD_SINGLE) begin
						l_nxt.idx = c[3:1];
					end else begin
						l_nxt.finished = 1'b1; // Test or unknown code
					end
				end
			end else if (l_r.cmd[sct_pkg::CMD_DIR]) begin
				// Read: single repeats its byte, burst walks on
				if (l_r.bit_cnt == 3'h7 && is_burst) begin
					l_nxt.idx = l_r.idx + 3'h1;
				end
			end else begin
				l_nxt.shift = d;
				if (l_r.bit_cnt == 3'h7) begin
					m_nxt.data[l_r.idx]  = d;
					m_nxt.burst[l_r.idx] = is_burst;
					m_nxt.tog[l_r.idx]   = !m_r.tog[l_r.idx];
					l_nxt.idx  = l_r.idx + 3'h1;
					if (is_single || l_r.idx == sct_pkg::IDX_LOCK) begin
						l_nxt.finished = 1'b1; // Extra clocks ignored
					end
				end
			end
		end
	end

	always_ff @(posedge shift_clock_i or posedge link_rst) begin
		if (link_rst) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	always_ff @(posedge shift_clock_i or posedge rst_i) begin
		if (rst_i) begin
			m_r <= '0;
		end else begin
			m_r <= m_nxt;
		end
	end

	// Falling edge: drive next read bit; shadow is frozen during a frame
	assign drive_nxt = l_r.cmd_done && l_r.cmd[sct_pkg::CMD_DIR] && !l_r.finished;
	always_ff @(negedge shift_clock_i or posedge link_rst) begin
		if (link_rst) begin
			data_line_oe_n_o <= 1'b1;
			data_line_o      <= 1'b0;
		end else begin
			data_line_oe_n_o <= !drive_nxt;
			data_line_o      <= s_r.shadow[l_r.idx][l_r.bit_cnt];
		end
	end

	// Crossing: a slot's toggle edge offers its byte to the FIFO, lowest slot
	// first; the byte stands in the mailbox until the next frame writes it
	assign pick        = sct_first(s_r.pending);
	assign wr_in.valid = |s_r.pending;
	assign wr_in.data  = {m_r.burst[pick], pick, m_r.data[pick]};
	// Drain stalls on a tick so counting and writes never collide
	assign wr_out.ready = !tick;
	assign tick = (s_r.prescale == tick_last) && !s_r.regs[sct_pkg::IDX_SEC][sct_pkg::HALT_BIT];

	sct_fifo #(.WIDTH(sct_pkg::WORD_W), .DEPTH(sct_pkg::FIFO_DEPTH)) u_fifo (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.push    (wr_in),
		.pop     (wr_out)
	);

	// System domain: calendar counting, writes, shadow refresh
	always_comb begin
		logic       c;
		logic       day;
		logic [7:0] h;
		logic [2:0] wi;
		logic       locked;
		logic [7:0] t;
		s_nxt = s_r;
		c = 1'b0;
		day = 1'b0;
		h = 8'h00;
		t = 8'h00;
		wi = wr_out.data[10:8];
		locked = s_r.regs[sct_pkg::IDX_LOCK][sct_pkg::LOCK_BIT];
		s_nxt.en_s1  = transfer_enable_line_i;
		s_nxt.en_s2  = s_r.en_s1;
		s_nxt.tog_s1 = m_r.tog;
		s_nxt.tog_s2 = s_r.tog_s1;
		s_nxt.tog_s3 = s_r.tog_s2;
		// New word sets pending, acceptance clears; set wins
		s_nxt.pending = (s_r.tog_s2 ^ s_r.tog_s3) |
			(s_r.pending & ~(wr_in.ready ? (8'h01 << pick) : 8'h00));
		// Divider halts with the oscillator
		if (s_r.regs[sct_pkg::IDX_SEC][sct_pkg::HALT_BIT] || tick) begin
			s_nxt.prescale = '0;
		end else begin
			s_nxt.prescale = s_r.prescale + 1'b1;
		end
		if (tick) begin
			// Seconds, then minutes carry
			if (s_r.regs[0][6:0] >= sct_pkg::BCD_59[6:0]) begin
				s_nxt.regs[0][6:0] = 7'h00;
				c = 1'b1;
			end else begin
				t = sct_bcd_inc({1'b0, s_r.regs[0][6:0]});
				s_nxt.regs[0][6:0] = t[6:0];
			end
			if (c) begin
				c = 1'b0;
				if (s_r.regs[1][6:0] >= sct_pkg::BCD_59[6:0]) begin
					s_nxt.regs[1][6:0] = 7'h00;
					c = 1'b1;
				end else begin
					t = sct_bcd_inc({1'b0, s_r.regs[1][6:0]});
					s_nxt.regs[1][6:0] = t[6:0];
				end
			end
			// Hours in either format
			if (c) begin
				c = 1'b0;
				h = s_r.regs[sct_pkg::IDX_HOUR];
				if (h[sct_pkg::HOUR12_BIT]) begin
					if (h[4:0] >= sct_pkg::BCD_12[4:0]) begin
						h[4:0] = sct_pkg::BCD_01[4:0];
					end else if (h[4:0] == sct_pkg::BCD_11[4:0]) begin
						h[4:0] = sct_pkg::BCD_12[4:0];
						day = h[sct_pkg::PM_BIT];
						h[sct_pkg::PM_BIT] = !h[sct_pkg::PM_BIT];
					end else begin
						t = sct_bcd_inc({3'h0, h[4:0]});
						h[4:0] = t[4:0];
					end
				end else begin
					if (h[5:0] >= sct_pkg::BCD_23[5:0]) begin
						h[5:0] = 6'h00;
						day = 1'b1;
					end else begin
						t = sct_bcd_inc({2'h0, h[5:0]});
						h[5:0] = t[5:0];
					end
				end
				s_nxt.regs[sct_pkg::IDX_HOUR] = h;
			end
			// Date, weekday, month, year
			if (day) begin
				if (s_r.regs[5] >= sct_pkg::BCD_07) begin
					s_nxt.regs[5] = sct_pkg::BCD_01;
				end else begin
					s_nxt.regs[5] = sct_bcd_inc(s_r.regs[5]);
				end
				if (s_r.regs[3] >= sct_month_end(s_r.regs[4], s_r.regs[6])) begin
					s_nxt.regs[3] = sct_pkg::BCD_01;
					c = 1'b1;
				end else begin
					s_nxt.regs[3] = sct_bcd_inc(s_r.regs[3]);
				end
			end
			if (c) begin
				c = 1'b0;
				if (s_r.regs[4] >= sct_pkg::BCD_12) begin
					s_nxt.regs[4] = sct_pkg::BCD_01;
					c = 1'b1;
				end else begin
					s_nxt.regs[4] = sct_bcd_inc(s_r.regs[4]);
				end
			end
			if (c) begin
				if (s_r.regs[6] >= sct_pkg::BCD_99) begin
					s_nxt.regs[6] = 8'h00;
				end else begin
					s_nxt.regs[6] = sct_bcd_inc(s_r.regs[6]);
				end
			end
		end
		// Host write: lock refuses all but a single write to the lock
		if (wr_out.valid && wr_out.ready) begin
			if ((!locked && !(wr_out.data[11] && wi == sct_pkg::IDX_LOCK)) ||
				(wi == sct_pkg::IDX_LOCK && !wr_out.data[11])) begin
				s_nxt.regs[wi] = wr_out.data[7:0] & sct_pkg::REG_MASK[wi];
			end
		end
		// Refresh the link copy only between frames
		if (!s_r.en_s2) begin
			s_nxt.shadow = s_r.regs;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			s_r <= '{regs: sct_pkg::REG_RESET, shadow: sct_pkg::REG_RESET, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Checks in the system domain
	AST_HALT_FREEZES: assert property (@(posedge clock_i) disable iff (rst_i)
		s_r.regs[0][7] && !wr_out.valid |=> s_r.regs[0] == $past(s_r.regs[0]))
		else $error("seconds moved while halted");
	AST_LOCK_REFUSES: assert property (@(posedge clock_i) disable iff (rst_i)
		s_r.regs[7][7] && wr_out.valid && wr_out.ready && wr_out.data[10:8] != 3'h7
		|=> s_r.regs[$past(wr_out.data[10:8])] == $past(s_r.regs[wr_out.data[10:8]]))
		else $error("locked write took effect");
	AST_LOCK_OPENS: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_out.valid && wr_out.ready && wr_out.data[11:8] == 4'h7
		|=> s_r.regs[7] == ($past(wr_out.data[7:0]) & 8'h80))
		else $error("lock register write lost");
	AST_SEC_WRAP: assert property (@(posedge clock_i) disable iff (rst_i)
		tick && s_r.regs[0][6:0] == 7'h59 |=> s_r.regs[0][6:0] == 7'h00
		&& s_r.regs[1] != $past(s_r.regs[1])) else $error("minute carry missed");
	AST_NOON: assert property (@(posedge clock_i) disable iff (rst_i)
		tick && s_r.regs[0][6:0] == 7'h59 && s_r.regs[1][6:0] == 7'h59
		&& s_r.regs[2][7] && s_r.regs[2][4:0] == 5'h11
		|=> s_r.regs[2][4:0] == 5'h12 && s_r.regs[2][5] != $past(s_r.regs[2][5]))
		else $error("12-hour noon roll wrong");
	AST_SHADOW_HELD: assert property (@(posedge clock_i) disable iff (rst_i)
		s_r.en_s2 && $past(s_r.en_s2) |-> $stable(s_r.shadow))
		else $error("link copy changed mid frame");
	AST_ABORT: assert property (@(posedge clock_i) disable iff (rst_i)
		!transfer_enable_line_i |-> data_line_oe_n_o) else $error("line driven while idle");
	// Checks in the link domain; the last two covers sample on the system clock
	AST_READ_ONLY_DRIVES: assert property (@(negedge shift_clock_i) disable iff (link_rst)
		!data_line_oe_n_o |-> l_r.cmd[0] && l_r.cmd[7]) else $error("drove on write");
	AST_SELECT: assert property (@(posedge shift_clock_i) disable iff (link_rst)
		!l_r.cmd_done ##1 l_r.cmd_done && is_single |-> l_r.idx == l_r.cmd[3:1])
		else $error("wrong register selected");
	AST_BURST_START: assert property (@(posedge shift_clock_i) disable iff (link_rst)
		!l_r.cmd_done ##1 l_r.cmd_done && is_burst |-> l_r.idx == 3'h0)
		else $error("burst not from register 0");
	COV_BURST_READ: cover property (@(posedge shift_clock_i) disable iff (link_rst)
		is_burst && l_r.cmd[0] && l_r.idx == 3'h7);
	COV_SINGLE_WRITE: cover property (@(posedge clock_i) disable iff (rst_i)
		wr_out.valid && wr_out.ready && !wr_out.data[11]);
	COV_DAY_ROLL: cover property (@(posedge clock_i) disable iff (rst_i)
		tick && s_r.regs[3] != s_nxt.regs[3]);
endmodule

// [sct_host_model.sv]
// Host model driving the three-wire link of the timekeeper
`timescale 1ns/100ps
module sct_host_model (
	output logic      sck_o, // Shift clock, still outside frames
	output logic      en_o,  // Frame enable
	output logic      hd_o,  // Host level on the data wire
	input  wire logic pin_i  // Resolved data wire
);
	localparam real HALF_NS = 6.0; // Half of the 12 ns shift clock
	localparam real SETUP_NS = 1000.0; // Enable to first shift clock, read copy freezes
	// Idle: clock and enable low
	initial begin
		sck_o = 1'b0;
		en_o  = 1'b0;
		hd_o  = 1'b0;
	end
	// One frame: command, then bytes; nbits nonzero cuts it short
	task automatic frame(input logic [7:0] cmd, input int nbytes,
		input logic [63:0] wdata, input int nbits, output logic [63:0] rdata);
		int k;
		int total;
		total = (nbits != 0) ? nbits : 8 + 8 * nbytes;
		rdata = '0;
		#3.3; // Keeps shift edges off the system clock edges
		en_o = 1'b1;
		#(SETUP_NS);
		for (k = 0; k < total; k++) begin
			if (k < 8) begin
				hd_o = cmd[k];
			end else if (cmd[0] == 1'b0) begin
				hd_o = wdata[k - 8];
			end else if (k == 8) begin
				hd_o = ~hd_o; // Released wire shows the inverse, not a stale bit
			end
			#(HALF_NS) sck_o = 1'b1;
			// Read bits taken on the rising edge
			if (k >= 8 && cmd[0]) begin
				rdata[k - 8] = pin_i;
			end
			#(HALF_NS) sck_o = 1'b0;
		end
		#(HALF_NS) en_o = 1'b0;
		hd_o = ~hd_o;
		// Gap lets the write land and the read copy refresh
		#1200;
	endtask
endmodule

// [tb_top.sv]
// Self-checking bench of the serial calendar timekeeper
`timescale 1ns/100ps
module tb_top;
	localparam int unsigned TICKS = 20;   // Short second of 2 us
	localparam int unsigned LIMIT = 2000; // Cycle ceiling for the run
	logic        clock_i;   // System clock
	logic        rst_i;     // Reset
	logic        sck;       // Shift clock from host
	logic        en;        // Frame enable from host
	logic        hd;        // Host level on the wire
	logic        data_o;    // Device output bit
	logic        oe_n;      // Device output enable, low drives
	logic        oe_seen;   // Device drove the wire
	wire logic   pin;       // Resolved data wire
	int          err_total; // Mismatches
	int          checked;   // Comparisons
	int          cycles;    // Clock cycles run
	logic [63:0] rd;        // Last read bytes
	int          i;
	int          n;
	// Wire: device wins while enabled, else the host level
	assign pin = oe_n ? hd : data_o;
	sct_timekeeper #(.TICK_CYCLES(TICKS)) dut (
		.clock_i               (clock_i),
		.rst_i                 (rst_i),
		.shift_clock_i         (sck),
		.transfer_enable_line_i(en),
		.data_line_i           (pin),
		.data_line_o           (data_o),
		.data_line_oe_n_o      (oe_n)
	);
	sct_host_model host (
		.sck_o(sck),
		.en_o (en),
		.hd_o (hd),
		.pin_i(pin)
	);
	// 100 ns system clock
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	// Hang guard
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_total++;
			conclude();
		end
	end
	// Notes any drive of the wire
	always @(oe_n) begin
		if (oe_n === 1'b0) oe_seen = 1'b1;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
		host.frame(cmd, 1, {56'h0, d}, 0, rd);
	endtask
	// Reset contents seen through a burst read
	task automatic t_reset();
		host.frame(8'hBF, 8, '0, 0, rd);
		for (i = 0; i < 8; i++) begin
			chk("reset", sct_pkg::REG_RESET[i], rd[8*i +: 8]);
		end
	endtask
	// Lock set: data write refused; lock write itself taken
	task automatic t_lock();
		wr(8'h82, 8'h25);
		oe_seen = 1'b0;
		host.frame(8'h83, 1, '0, 0, rd);
		chk("locked min", 8'h00, rd[7:0]);
		chk("drove", 8'h01, {7'h0, oe_seen});
		wr(8'h8E, 8'h00);
		host.frame(8'h8F, 1, '0, 0, rd);
		chk("lock", 8'h00, rd[7:0]);
	endtask
	// Single commands of registers 0 to 6, reserved bits masked, byte repeated
	task automatic t_single();
		logic [7:0] v [7];
		v = '{8'hC5, 8'h59, 8'h23, 8'h31, 8'h12, 8'hF7, 8'h99};
		for (n = 0; n < 7; n++) begin
			wr({4'h8, n[2:0], 1'b0}, v[n]);
			host.frame({4'h8, n[2:0], 1'b1}, 2, '0, 0, rd);
			chk("single", v[n] & sct_pkg::REG_MASK[n], rd[7:0]);
			chk("repeat", v[n] & sct_pkg::REG_MASK[n], rd[15:8]);
		end
	endtask
	// Burst write, run, carry through the calendar; halted first so the
	// divider restarts and no tick falls between the landing bytes
	task automatic t_roll(input logic [63:0] w, input logic [63:0] e);
		wr(8'h80, 8'h80);
		host.frame(8'hBE, 8, w, 0, rd);
		#1800;
		host.frame(8'hBF, 8, '0, 0, rd);
		chk("sec", 8'h00, rd[7:0] & 8'hFE);
		for (i = 1; i < 8; i++) begin
			chk("roll", e[8*i +: 8], rd[8*i +: 8]);
		end
	endtask
	// Halted seconds stand still
	task automatic t_halt();
		wr(8'h80, 8'h80);
		host.frame(8'h81, 1, '0, 0, rd);
		chk("halt a", 8'h80, rd[7:0]);
		#5000;
		host.frame(8'h81, 1, '0, 0, rd);
		chk("halt b", 8'h80, rd[7:0]);
	endtask
	// Enable dropped mid-frame: line released, partial byte dropped
	task automatic t_abort();
		logic [7:0] c [2];
		c = '{8'h83, 8'h82};
		for (n = 0; n < 2; n++) begin
			host.frame(c[n], 1, 64'h33, 12, rd);
			chk("oe_n", 8'h01, {7'h0, oe_n});
			host.frame(8'h83, 1, '0, 0, rd);
			chk("min", 8'h00, rd[7:0]);
		end
	endtask
	// Test command ignored, wire never driven
	task automatic t_test();
		oe_seen = 1'b0;
		host.frame(8'h93, 1, '0, 0, rd);
		chk("test", 8'h00, {7'h0, oe_seen});
	endtask
	// Main sequence
	initial begin
		rst_i = 1'b1;
		err_total = 0;
		checked = 0;
		cycles = 0;
		oe_seen = 1'b0;
		repeat (16) @(posedge clock_i);
		@(negedge clock_i) rst_i = 1'b0;
		repeat (3) @(negedge clock_i);
		t_reset();
		t_lock();
		t_single();
		t_roll(64'h80_99_07_12_31_23_59_59, 64'h00_00_01_01_01_00_00_00);
		t_roll(64'h80_24_03_02_28_B1_59_59, 64'h00_24_04_02_29_92_00_00);
		t_halt();
		t_abort();
		t_test();
		conclude();
	end
endmodule
